/* File: design/mgrw_params.svh */
`ifndef MGRW_PARAMS_SVH
`define MGRW_PARAMS_SVH

`define MGRW_ADDR_W 8
`define MGRW_DATA_W 8
`define MGRW_N_OUT 8
`define MGRW_N_CFG 8
`define MGRW_ADDR_MODE 8'h00
`define MGRW_ADDR_SS 8'h01
`define MGRW_ADDR_OE 8'h02
`define MGRW_ADDR_INSEL 8'h03
`define MGRW_ADDR_CFG_BASE 8'h10
`define MGRW_ADDR_CFG_MASK 8'hf8
`define MGRW_MODE_BIT 0
`define MGRW_SS_BIT 0
`define MGRW_INSEL_LSB 0
`define MGRW_INSEL_W 2
`define MGRW_RST_SS 1'b0
`define MGRW_RST_OE 8'hff
`define MGRW_RST_INSEL 2'h0
`define MGRW_RST_CFG 8'h00

`endif

/* File: design/mgrw_pkg.sv */
`include "mgrw_params.svh"

package mgrw_pkg;

	typedef enum logic [0:0]
	{
		MGRW_READY = 1'b0,
		MGRW_ACTIVE = 1'b1
	} mgrw_mode_t;

	typedef logic [`MGRW_DATA_W-1:0] mgrw_byte_t;
	typedef logic [`MGRW_ADDR_W-1:0] mgrw_addr_t;
	typedef logic [$clog2(`MGRW_N_CFG)-1:0] mgrw_cfg_idx_t;

	function automatic logic mgrw_is_cfg(input mgrw_addr_t a);
		return (a & `MGRW_ADDR_CFG_MASK) == `MGRW_ADDR_CFG_BASE;
	endfunction

	function automatic mgrw_cfg_idx_t mgrw_cfg_idx(input mgrw_addr_t a);
		return a[$clog2(`MGRW_N_CFG)-1:0];
	endfunction

endpackage

/* File: design/mgrw_cfg_if.sv */
`timescale 1ns/100ps
`default_nettype none

`include "mgrw_params.svh"

interface mgrw_cfg_if;
	logic wr_en;
	mgrw_pkg::mgrw_cfg_idx_t wr_idx;
	mgrw_pkg::mgrw_byte_t wr_data;
	logic commit;
	mgrw_pkg::mgrw_cfg_idx_t rd_idx;
	mgrw_pkg::mgrw_byte_t rd_staged;
	logic [`MGRW_N_CFG*`MGRW_DATA_W-1:0] active_flat;

	modport ctrl
	(
		output wr_en,
		output wr_idx,
		output wr_data,
		output commit,
		output rd_idx,
		input rd_staged,
		input active_flat
	);

	modport store
	(
		input wr_en,
		input wr_idx,
		input wr_data,
		input commit,
		input rd_idx,
		output rd_staged,
		output active_flat
	);
endinterface

`default_nettype wire

/* File: design/mgrw_cfg_store.sv */
`timescale 1ns/100ps
`default_nettype none

`include "mgrw_params.svh"

module mgrw_cfg_store
(
	input wire logic core_clk,
	input wire logic rst_b,
	mgrw_cfg_if.store cfg
);

	mgrw_pkg::mgrw_byte_t staged_reg [`MGRW_N_CFG];
	mgrw_pkg::mgrw_byte_t active_reg [`MGRW_N_CFG];

	assign cfg.rd_staged = staged_reg[cfg.rd_idx];

	always_ff @(posedge core_clk)
	begin
		for (int i = 0; i < `MGRW_N_CFG; i++)
		begin
			if (!rst_b)
			begin
				staged_reg[i] <= `MGRW_RST_CFG;
				active_reg[i] <= `MGRW_RST_CFG;
			end
			else
			begin
				// Staging write already gated by the controller
				if (cfg.wr_en && cfg.wr_idx == i[$clog2(`MGRW_N_CFG)-1:0])
					staged_reg[i] <= cfg.wr_data;
				if (cfg.commit)
					active_reg[i] <= staged_reg[i];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < `MGRW_N_CFG; g++)
		begin : g_flat
			assign cfg.active_flat[g*`MGRW_DATA_W +: `MGRW_DATA_W] = active_reg[g];
		end
	endgenerate

endmodule

`default_nettype wire

/* File: design/mgrw_top.sv */
`timescale 1ns/100ps
`default_nettype none

`include "mgrw_params.svh"

module mgrw_top
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [`MGRW_ADDR_W-1:0] wr_addr,
	input wire logic [`MGRW_DATA_W-1:0] wr_data,
	input wire logic [`MGRW_ADDR_W-1:0] rd_addr,
	output logic [`MGRW_DATA_W-1:0] rd_data,
	output logic wr_ack,
	output logic mode_active,
	output logic outputs_running,
	output logic [`MGRW_N_OUT-1:0] out_run,
	output logic ss_enable,
	output logic [`MGRW_INSEL_W-1:0] input_sel,
	output logic [`MGRW_N_CFG*`MGRW_DATA_W-1:0] cfg_active
);

	mgrw_cfg_if cfg ();

	mgrw_pkg::mgrw_mode_t mode_reg;
	mgrw_pkg::mgrw_mode_t mode_next;
	logic ss_reg;
	logic [`MGRW_N_OUT-1:0] oe_reg;
	logic [`MGRW_INSEL_W-1:0] insel_reg;
	logic [`MGRW_N_OUT-1:0] out_run_reg;
	logic [`MGRW_DATA_W-1:0] rd_data_reg;
	logic wr_ack_reg;

	function automatic logic mgrw_addr_hit
	(
		input logic en,
		input mgrw_pkg::mgrw_addr_t a,
		input mgrw_pkg::mgrw_addr_t match_addr
	);
		return en && a == match_addr;
	endfunction

	wire wr_mode = mgrw_addr_hit(wr_en, wr_addr, `MGRW_ADDR_MODE);
	wire wr_ss = mgrw_addr_hit(wr_en, wr_addr, `MGRW_ADDR_SS);
	wire wr_oe = mgrw_addr_hit(wr_en, wr_addr, `MGRW_ADDR_OE);
	wire wr_insel = mgrw_addr_hit(wr_en, wr_addr, `MGRW_ADDR_INSEL);
	wire wr_cfg_hit = wr_en && mgrw_pkg::mgrw_is_cfg(wr_addr);
	wire rd_cfg_hit = mgrw_pkg::mgrw_is_cfg(rd_addr);
	wire req_active = wr_data[`MGRW_MODE_BIT];
	wire mode_is_ready = mode_reg == mgrw_pkg::MGRW_READY;

	wire cfg_wr_ok = wr_cfg_hit && mode_is_ready;

	// commit edge
	// Only a real Ready-to-Active step commits, so rewriting Active is harmless
	wire commit = wr_mode && req_active && mode_is_ready;

	assign mode_next = wr_mode ? (req_active ? mgrw_pkg::MGRW_ACTIVE : mgrw_pkg::MGRW_READY) : mode_reg;

	assign cfg.wr_en = cfg_wr_ok;
	assign cfg.wr_idx = mgrw_pkg::mgrw_cfg_idx(wr_addr);
	assign cfg.wr_data = wr_data;
	assign cfg.commit = commit;
	assign cfg.rd_idx = mgrw_pkg::mgrw_cfg_idx(rd_addr);

	mgrw_cfg_store u_store
	(
		.core_clk(core_clk),
		.rst_b(rst_b),
		.cfg(cfg)
	);

	// Output run mask follows the mode and enables written this cycle
	logic [`MGRW_N_OUT-1:0] oe_next;
	logic [`MGRW_N_OUT-1:0] out_run_next;

	assign oe_next = wr_oe ? wr_data[`MGRW_N_OUT-1:0] : oe_reg;
	assign out_run_next = (mode_next == mgrw_pkg::MGRW_ACTIVE) ? oe_next : '0;

	// Read selection; unmapped addresses read zero
	wire rd_sel_mode = mgrw_addr_hit(1'b1, rd_addr, `MGRW_ADDR_MODE);
	wire rd_sel_ss = mgrw_addr_hit(1'b1, rd_addr, `MGRW_ADDR_SS);
	wire rd_sel_oe = mgrw_addr_hit(1'b1, rd_addr, `MGRW_ADDR_OE);
	wire rd_sel_insel = mgrw_addr_hit(1'b1, rd_addr, `MGRW_ADDR_INSEL);

	logic [`MGRW_DATA_W-1:0] rd_mode_word;
	logic [`MGRW_DATA_W-1:0] rd_ss_word;
	logic [`MGRW_DATA_W-1:0] rd_oe_word;
	logic [`MGRW_DATA_W-1:0] rd_insel_word;
	logic [`MGRW_DATA_W-1:0] rd_next;

	assign rd_mode_word = mgrw_pkg::mgrw_byte_t'(mode_reg == mgrw_pkg::MGRW_ACTIVE) << `MGRW_MODE_BIT;
	assign rd_ss_word = mgrw_pkg::mgrw_byte_t'(ss_reg) << `MGRW_SS_BIT;
	assign rd_oe_word = mgrw_pkg::mgrw_byte_t'(oe_reg);
	assign rd_insel_word = mgrw_pkg::mgrw_byte_t'(insel_reg) << `MGRW_INSEL_LSB;

	// Staged bytes read back, so the host can check them before committing
	assign rd_next = rd_cfg_hit ? cfg.rd_staged
		: rd_sel_mode ? rd_mode_word
		: rd_sel_ss ? rd_ss_word
		: rd_sel_oe ? rd_oe_word
		: rd_sel_insel ? rd_insel_word
		: '0;

	logic ss_next;
	logic [`MGRW_INSEL_W-1:0] insel_next;

	assign ss_next = wr_ss ? wr_data[`MGRW_SS_BIT] : ss_reg;
	assign insel_next = wr_insel ? wr_data[`MGRW_INSEL_LSB +: `MGRW_INSEL_W] : insel_reg;

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			mode_reg <= mgrw_pkg::MGRW_ACTIVE;
		end
		else
		begin
			mode_reg <= mode_next;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			out_run_reg <= `MGRW_RST_OE;
		end
		else
		begin
			out_run_reg <= out_run_next;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			ss_reg <= `MGRW_RST_SS;
		end
		else
		begin
			ss_reg <= ss_next;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			oe_reg <= `MGRW_RST_OE;
		end
		else
		begin
			oe_reg <= oe_next;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			insel_reg <= `MGRW_RST_INSEL;
		end
		else
		begin
			insel_reg <= insel_next;
		end
	end

	// refused writes still acked
	// Ack every write so a refused one looks like any other to the host
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			wr_ack_reg <= 1'b0;
		end
		else
		begin
			wr_ack_reg <= wr_en;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			rd_data_reg <= '0;
		end
		else
		begin
			rd_data_reg <= rd_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign wr_ack = wr_ack_reg;
	assign mode_active = (mode_reg == mgrw_pkg::MGRW_ACTIVE);
	assign outputs_running = |out_run_reg;
	assign out_run = out_run_reg;
	assign ss_enable = ss_reg;
	assign input_sel = insel_reg;
	assign cfg_active = cfg.active_flat;

endmodule

`default_nettype wire

/* File: tb/mgrw_chk_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module mgrw_chk
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic wr_ack,
	input wire logic mode_active,
	input wire logic outputs_running,
	input wire logic [7:0] out_run,
	input wire logic ss_enable,
	input wire logic [63:0] cfg_active
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire cw = wr_en && wr_addr[7:3] == 5'h02;
	wire mw = wr_en && wr_addr == 8'h00;
	property p_ack; wr_en |=> wr_ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_run; !mode_active |-> out_run == 8'h00 && !outputs_running; endproperty
	a_run: assert property (p_run) else $error("runs");
	property p_gate; mode_active && cw |=> $stable(cfg_active); endproperty
	a_gate: assert property (p_gate) else $error("gate");
	property p_keep;
		mode_active && cw && rd_addr == wr_addr ##1 $stable(rd_addr) |=> $stable(rd_data);
	endproperty
	a_keep: assert property (p_keep) else $error("refused write stored");
	property p_stg;
		!mode_active && cw && rd_addr == wr_addr ##1 $stable(rd_addr) |=> rd_data == $past(wr_data, 2);
	endproperty
	a_stg: assert property (p_stg) else $error("staged write lost");
	property p_stop; mode_active && mw && !wr_data[0] |=> !mode_active && !outputs_running; endproperty
	a_stop: assert property (p_stop) else $error("stop");
	property p_hold; !mode_active && !(mw && wr_data[0]) |=> $stable(cfg_active); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_ss; wr_en && wr_addr == 8'h01 |=> ss_enable == $past(wr_data[0]); endproperty
	a_ss: assert property (p_ss) else $error("ss");
	property p_oe; mode_active && wr_en && wr_addr == 8'h02 |=> out_run == $past(wr_data); endproperty
	a_oe: assert property (p_oe) else $error("oe");
	// Sampled rst_b masks the release edge
	property p_stat; rst_b && rd_addr == 8'h00 |=> rd_data[0] == $past(mode_active); endproperty
	a_stat: assert property (p_stat) else $error("status");
	c_cm: cover property (!mode_active && mw && wr_data[0]);
	c_rf: cover property (mode_active && cw);
	c_st: cover property (!mode_active && cw);
endmodule
`default_nettype wire

/* File: tb/mgrw_host.sv */
`timescale 1ns/100ps
`default_nettype none
module mgrw_host
(
	input wire logic core_clk,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data
);
	initial
	begin
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
	end
	// Released lines show inverted junk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge core_clk);
		wr_en <= 1'b0;
		wr_addr <= ~a;
		wr_data <= ~d;
	endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] rd_addr = 8'h00;
	logic wr_en, wr_ack, mode_active, outputs_running, ss_enable, m, ss;
	logic [7:0] wr_addr, wr_data, rd_data, out_run, oe;
	logic [1:0] input_sel, insel;
	logic [63:0] cfg_active, stg, act;
	logic [76:0] q[$];
	integer seed = 32'he757;
	int mismatches = 0, total_checks = 0, cyc = 0;
	always #12.5 core_clk = ~core_clk;
	mgrw_top mgrw_top_inst(.*);
	mgrw_host mgrw_host_inst(.*);
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input logic [76:0] e, input logic [76:0] s);
		total_checks++;
		if (e !== s)
		begin
			mismatches++;
			$display("unexpected state exp %h seen %h", e, s);
		end
	endtask
	task automatic cmp_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (e !== s)
		begin
			mismatches++;
			$display("unexpected rd_data at %h exp %h seen %h", a, e, s);
		end
	endtask
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		exp_rd = 8'h00;
		if (a == 8'h00)
			exp_rd[0] = m;
		if (a == 8'h01)
			exp_rd[0] = ss;
		if (a == 8'h02)
			exp_rd = oe;
		if (a == 8'h03)
			exp_rd[1:0] = insel;
		if (a[7:3] == 5'h02)
			exp_rd = stg[a[2:0]*8+:8];
	endfunction
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		rd_addr <= a;
		@(posedge core_clk);
		@(negedge core_clk);
		cmp_rd(a, exp_rd(a), rd_data);
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		if (a == 8'h00)
		begin
			if (!m && d[0])
				act = stg;
			m = d[0];
		end
		if (a == 8'h01)
			ss = d[0];
		if (a == 8'h02)
			oe = d;
		if (a == 8'h03)
			insel = d[1:0];
		if (a[7:3] == 5'h02 && !m)
			stg[a[2:0]*8+:8] = d;
		q.push_back({m, |(m ? oe : 8'h00), m ? oe : 8'h00, act, ss, insel});
		mgrw_host_inst.wr(a, d);
	endtask
	// Negedge keeps clear of update races
	always @(negedge core_clk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			mismatches++;
			close_out();
		end
		if (wr_ack === 1'b1 && q.size() > 0)
			cmp(q.pop_front(), {mode_active, outputs_running, out_run, cfg_active, ss_enable, input_sel});
	end
	initial
	begin
		m = 1'b1;
		oe = 8'hff;
		ss = 1'b0;
		insel = 2'h0;
		stg = '0;
		act = '0;
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		// Watch one gated byte while it is written
		rd_addr <= 8'h12;
		for (int i = 0; i < 8; i++)
			w(8'(8'h10 + i), 8'($random(seed)));
		$display("test active done");
		w(8'h00, 8'h00);
		for (int i = 0; i < 8; i++)
			w(8'(8'h10 + i), 8'($random(seed)));
		w(8'h02, 8'h0f);
		w(8'h00, 8'h01);
		$display("test ready done");
		repeat (80)
			w(8'($random(seed)) & 8'h57, 8'($random(seed)));
		$display("test random done");
		for (int i = 0; i < 24; i++)
			rd(8'(i));
		$display("test read done");
		repeat (3) @(posedge core_clk);
		close_out();
	end
endmodule
bind mgrw_top mgrw_chk mgrw_chk_inst(.*);
`default_nettype wire
